// file: pkg/vai_pkg.sv
package vai_pkg;

   // ----------------------------------------------------------------
   // Device register map
   // ----------------------------------------------------------------
   localparam int NREG = 36;
   localparam logic [6:0] SLAVE_ADDR_BASE = 7'h4c;
   // Arbitrary identification value, not tied to any real part.
   localparam logic [7:0] CHIP_ID = 8'h5a;
   localparam logic [7:0] ADR_ID = 8'h00;
   localparam logic [7:0] ADR_DIV_UPPER = 8'h01;
   localparam logic [7:0] ADR_DIV_LOWER = 8'h02;
   localparam logic [7:0] ADR_LOOP_SET = 8'h03;
   localparam logic [7:0] ADR_GAIN0 = 8'h08;
   localparam logic [7:0] ADR_CLAMP_LVL = 8'h10;
   localparam logic [7:0] ADR_OFFSET0 = 8'h17;
   localparam logic [7:0] ADR_BLACK0 = 8'h1d;
   localparam logic [7:0] ADR_LOOP_CTRL = 8'h23;
   localparam int CPI_LSB = 3;
   localparam int DIV_LOW_LSB = 4;
   localparam int LOOP_RUN_BIT = 2;
   localparam logic [1:0] LOOP_ALWAYS = 2'h0;
   localparam logic [1:0] LOOP_REGCTL = 2'h1;
   localparam logic [1:0] LOOP_OFF = 2'h2;

   function automatic logic [7:0] reg_default(int a);
      case (a)
         8'h00: return CHIP_ID;
         8'h01: return 8'h69;
         8'h02: return 8'hd0;
         8'h03: return 8'h48;
         8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0a: return 8'h80;
         8'h07, 8'h11: return 8'h20;
         8'h0e: return 8'h40;
         8'h0f: return 8'h4a;
         8'h10: return 8'hb8;
         8'h15: return 8'h02;
         8'h17, 8'h19, 8'h1b: return 8'h01;
         default: return 8'h00;
      endcase
   endfunction

   // Bits that software may change; read-only and reserved bits keep
   // their default so they always read back the same.
   function automatic logic [7:0] reg_wmask(int a);
      case (a)
         8'h00, 8'h0b, 8'h0c, 8'h0d, 8'h14: return 8'h00;
         8'h02: return 8'hf0;
         8'h03, 8'h04: return 8'hf8;
         8'h0e: return 8'h6d;
         8'h0f: return 8'hea;
         8'h15: return 8'h02;
         8'h17, 8'h19, 8'h1b, 8'h1d, 8'h1f, 8'h21: return 8'h01;
         8'h23: return 8'h07;
         default: return 8'hff;
      endcase
   endfunction

   function automatic logic [NREG-1:0][7:0] build_defaults();
      logic [NREG-1:0][7:0] d;
      for (int i = 0; i < NREG; i++)
      begin
         d[i] = reg_default(i);
      end
      return d;
   endfunction

   localparam logic [NREG-1:0][7:0] REG_DEF = build_defaults();

   // ----------------------------------------------------------------
   // Host command registers
   // ----------------------------------------------------------------
   localparam logic [3:0] H_CTRL = 4'h0;
   localparam logic [3:0] H_SUB = 4'h1;
   localparam logic [3:0] H_WDATA = 4'h2;
   localparam logic [3:0] H_RDATA = 4'h3;
   localparam logic [3:0] H_STAT = 4'h4;
   localparam logic [3:0] H_TARGET = 4'h5;
   localparam int CTRL_GO = 0;
   localparam int CTRL_READ = 1;
   localparam int STAT_BUSY = 0;
   localparam int STAT_NACK = 1;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int SCL_PERIOD_NS = 2500;
   localparam int SCL_QUARTER_CYC =
      (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// file: pkg/vai_link_if.sv
interface vai_link_if;
   logic scl;
   logic sda;
   logic sda_m_o;
   logic sda_m_oe_n;
   logic sda_s_o;
   logic sda_s_oe_n;

   // ----------------------------------------------------------------
   // Wired-and bus with pull-up
   // ----------------------------------------------------------------
   assign sda = ((!sda_m_oe_n && !sda_m_o) || (!sda_s_oe_n && !sda_s_o))
      ? 1'b0 : 1'b1;

   modport master (output scl, output sda_m_o, output sda_m_oe_n,
                   input sda);
   modport slave (input scl, input sda, output sda_s_o,
                  output sda_s_oe_n);
endinterface

// file: rtl/vai_dev.sv
// Functional notes
// - Address 1001100 or 1001101 by strap.
// - Sample data on rising clock edge.
// - Data changes only while clock low.
// - Data edges with clock high: start/stop.
// - Bytes: address, sub-address, then data.
// - Eight-bit fields each followed by acknowledge.
// - Sequential writes go to consecutive addresses.
// - Reads stream from sub-address until not-acknowledge.
// - Master makes conditions, acks reads but last.
// - Device drives acks and read data.
// - Host resets after power-up, over 1 us; the bench holds its first reset for 16 cycles, 400 ns.
// - Reset restores every register default.
// - Divider spans registers 0x01 and 0x02.
// - Pump current in bits 5:3 of 0x03.
// - Register 10H picks minimum or centre clamp.
// - Eight-bit gain code per channel.
// - Per-channel black target, -4 to +20.
// - Loop always, register-held, or off.
module vai_dev (
   input wire logic rstn,
   vai_link_if.slave lnk,
   input wire logic address_select_strap,
   output logic [11:0] pll_divider,
   output logic [2:0] charge_pump_current,
   output logic [2:0][7:0] programmable_gain_stage,
   output logic [2:0] clamp_mid,
   output logic [2:0][8:0] black_level,
   output logic [2:0][8:0] channel_offset,
   output logic offset_enable,
   output logic [1:0] loop_mode,
   output logic loop_run
);

   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_SUB, ST_WDATA, ST_RDATA
   } vai_dev_state_t;

   typedef struct packed {
      vai_dev_state_t st;
      logic [3:0] cnt;
      logic [7:0] shreg;
      logic [7:0] tx;
      logic [7:0] ptr;
      logic dev_ack;
      logic [1:0] strap_sync;
      logic start_seen;
      logic stop_seen;
      logic off_en;
      logic [vai_pkg::NREG-1:0][7:0] regs;
   } vai_dev_reg_t;

   vai_dev_reg_t r;
   vai_dev_reg_t next_r;
   logic start_tgl;
   logic stop_tgl;
   logic sda_low;
   logic [7:0] byte_v;
   logic [6:0] my_addr;

   function automatic logic [7:0] reg_read(
      input logic [vai_pkg::NREG-1:0][7:0] regs, input logic [7:0] a);
      if (int'(a) < vai_pkg::NREG)
      begin
         return regs[a[5:0]];
      end
      return 8'h00;
   endfunction

   // ----------------------------------------------------------------
   // Start and stop detection
   // ----------------------------------------------------------------
   // These toggles run on the data line itself, so a stop is caught even
   // though no clock edge follows it. The condition has settled long
   // before the next rising clock edge compares the toggles.
   // start on falling data
   always_ff @(negedge lnk.sda or negedge rstn)
   begin
      if (!rstn)
         start_tgl <= 1'b0;
      else if (lnk.scl)
         start_tgl <= ~start_tgl;
   end

   always_ff @(posedge lnk.sda or negedge rstn)
   begin
      if (!rstn)
         stop_tgl <= 1'b0;
      else if (lnk.scl)
         stop_tgl <= ~stop_tgl;
   end

   // ----------------------------------------------------------------
   // Receive side, rising clock edge
   // ----------------------------------------------------------------
   // strap picks address bit
   assign my_addr = {vai_pkg::SLAVE_ADDR_BASE[6:1], r.strap_sync[1]};

   always_comb
   begin
      next_r = r;
      byte_v = {r.shreg[6:0], lnk.sda};
      next_r.strap_sync = {r.strap_sync[0], address_select_strap};
      next_r.start_seen = start_tgl;
      next_r.stop_seen = stop_tgl;
      if (start_tgl != r.start_seen)
      begin
         next_r.st = ST_ADDR;
         next_r.cnt = 4'd1;
         next_r.shreg = {7'h00, lnk.sda};
         next_r.dev_ack = 1'b0;
      end
      else if (stop_tgl != r.stop_seen || r.st == ST_IDLE)
      begin
         next_r.st = ST_IDLE;
         next_r.cnt = 4'd0;
         next_r.dev_ack = 1'b0;
      end
      else if (r.cnt == 4'd8)
      begin
         next_r.cnt = 4'd0;
         next_r.dev_ack = 1'b0;
         if (r.st == ST_RDATA)
         begin
            if (!r.dev_ack && lnk.sda)
            begin
               next_r.st = ST_IDLE;
            end
            else
            begin
               next_r.tx = reg_read(r.regs, r.ptr);
               next_r.ptr = r.ptr + 8'd1;
            end
         end
      end
      else
      begin
         next_r.shreg = byte_v;
         next_r.cnt = r.cnt + 4'd1;
         if (r.cnt == 4'd7)
         begin
            next_r.dev_ack = 1'b1;
            unique case (r.st)
               ST_ADDR:
               begin
                  if (byte_v[7:1] == my_addr)
                  begin
                     next_r.st = byte_v[0] ? ST_RDATA : ST_SUB;
                  end
                  else
                  begin
                     next_r.st = ST_IDLE;
                     next_r.dev_ack = 1'b0;
                     next_r.cnt = 4'd0;
                  end
               end
               ST_SUB:
               begin
                  next_r.ptr = byte_v;
                  next_r.st = ST_WDATA;
               end
               ST_WDATA:
               begin
                  if (int'(r.ptr) < vai_pkg::NREG)
                  begin
                     next_r.regs[r.ptr[5:0]] =
                        (r.regs[r.ptr[5:0]] &
                         ~vai_pkg::reg_wmask(int'(r.ptr))) |
                        (byte_v & vai_pkg::reg_wmask(int'(r.ptr)));
                  end
                  next_r.ptr = r.ptr + 8'd1;
               end
               ST_RDATA:
               begin
                  next_r.dev_ack = 1'b0;
               end
               ST_IDLE:
               begin
                  next_r.dev_ack = 1'b0;
               end
            endcase
         end
      end
      // offsets valid only with loop off
      next_r.off_en = next_r.regs[vai_pkg::ADR_LOOP_CTRL][1:0] ==
         vai_pkg::LOOP_OFF;
   end

   always_ff @(posedge lnk.scl or negedge rstn)
   begin
      if (!rstn)
      begin
         r <= '0;
         r.st <= ST_IDLE;
         r.regs <= vai_pkg::REG_DEF;
      end
      else
      begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------
   // Transmit side, falling clock edge
   // ----------------------------------------------------------------
   // drive changes on falling clock
   always_ff @(negedge lnk.scl or negedge rstn)
   begin
      if (!rstn)
         sda_low <= 1'b0;
      else
         sda_low <= (r.dev_ack && r.cnt == 4'd8) ||
            (r.st == ST_RDATA && !r.dev_ack && r.cnt < 4'd8 &&
             !r.tx[3'd7 - r.cnt[2:0]]);
   end

   assign lnk.sda_s_o = 1'b0;
   assign lnk.sda_s_oe_n = ~sda_low;

   // ----------------------------------------------------------------
   // Configuration outputs
   // ----------------------------------------------------------------
   // divider from two registers
   assign pll_divider = {r.regs[vai_pkg::ADR_DIV_UPPER],
      r.regs[vai_pkg::ADR_DIV_LOWER][7:vai_pkg::DIV_LOW_LSB]};
   assign charge_pump_current =
      r.regs[vai_pkg::ADR_LOOP_SET][vai_pkg::CPI_LSB +: 3];
   assign offset_enable = r.off_en;
   assign loop_mode = r.regs[vai_pkg::ADR_LOOP_CTRL][1:0];
   assign loop_run = r.regs[vai_pkg::ADR_LOOP_CTRL][vai_pkg::LOOP_RUN_BIT];

   for (genvar c = 0; c < 3; c++)
   begin : g_chan
      assign programmable_gain_stage[c] =
         r.regs[vai_pkg::ADR_GAIN0 + c];
      assign clamp_mid[c] = r.regs[vai_pkg::ADR_CLAMP_LVL][2 - c];
      assign black_level[c] = {r.regs[vai_pkg::ADR_BLACK0 + 2 * c][0],
         r.regs[vai_pkg::ADR_BLACK0 + 2 * c + 1]};
      assign channel_offset[c] = {r.regs[vai_pkg::ADR_OFFSET0 + 2 * c][0],
         r.regs[vai_pkg::ADR_OFFSET0 + 2 * c + 1]};
   end

endmodule

// file: rtl/vai_host.sv
module vai_host #(
   parameter int QUARTER = vai_pkg::SCL_QUARTER_CYC
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   vai_link_if.master lnk
);

   typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP}
      vai_host_state_t;

   typedef struct packed {
      vai_host_state_t st;
      logic [15:0] div;
      logic [1:0] q;
      logic [3:0] bitn;
      logic [1:0] seq;
      logic [7:0] shreg;
      logic [7:0] rx;
      logic scl;
      logic sda_rel;
      logic [1:0] sda_sync;
      logic [7:0] sub;
      logic [7:0] wbyte;
      logic [7:0] rbyte;
      logic [6:0] target;
      logic rd_op;
      logic busy;
      logic nack;
      logic [7:0] rd_q;
   } vai_host_reg_t;

   vai_host_reg_t r;
   vai_host_reg_t next_r;
   logic tick;
   logic rd_byte;

   // The synchroniser adds two cycles before sampling, so a quarter
   // must be longer than that.
   if (QUARTER < 4 || QUARTER > 65535)
   begin : g_bad_quarter
      $error("QUARTER out of range");
   end

   function automatic logic [7:0] byte_for(input vai_host_reg_t s,
      input logic [1:0] seq);
      unique case (seq)
         2'd0: return {s.target, 1'b0};
         2'd1: return s.sub;
         default: return s.rd_op ? {s.target, 1'b1} : s.wbyte;
      endcase
   endfunction

   assign tick = r.div == 16'(QUARTER - 1);
   assign rd_byte = r.rd_op && r.seq == 2'd3;

   always_comb
   begin
      next_r = r;
      next_r.sda_sync = {r.sda_sync[0], lnk.sda};
      next_r.div = tick ? 16'd0 : r.div + 16'd1;
      next_r.rd_q = 8'h00;
      if (rd)
      begin
         unique case (addr)
            vai_pkg::H_SUB: next_r.rd_q = r.sub;
            vai_pkg::H_WDATA: next_r.rd_q = r.wbyte;
            vai_pkg::H_RDATA: next_r.rd_q = r.rbyte;
            vai_pkg::H_STAT: next_r.rd_q = {6'h00, r.nack, r.busy};
            vai_pkg::H_TARGET: next_r.rd_q = {1'b0, r.target};
            default: next_r.rd_q = 8'h00;
         endcase
      end
      if (wr)
      begin
         unique case (addr)
            vai_pkg::H_SUB: next_r.sub = wdata;
            vai_pkg::H_WDATA: next_r.wbyte = wdata;
            vai_pkg::H_TARGET: next_r.target = wdata[6:0];
            vai_pkg::H_CTRL:
               if (wdata[vai_pkg::CTRL_GO] && !r.busy)
               begin
                  next_r.rd_op = wdata[vai_pkg::CTRL_READ];
                  next_r.busy = 1'b1;
                  next_r.nack = 1'b0;
                  next_r.st = H_START;
                  next_r.q = 2'd0;
                  next_r.seq = 2'd0;
                  next_r.div = 16'd0;
               end
            default: next_r.busy = r.busy;
         endcase
      end
      if (tick && r.st != H_IDLE)
      begin
         next_r.q = r.q + 2'd1;
         if (r.st == H_BYTE && r.q == 2'd2)
         begin
            if (r.bitn == 4'd8 && !rd_byte && r.sda_sync[1])
               next_r.nack = 1'b1;
            if (r.bitn < 4'd8)
               next_r.rx = {r.rx[6:0], r.sda_sync[1]};
         end
         if (r.q == 2'd3)
         begin
            unique case (r.st)
               H_START:
               begin
                  next_r.st = H_BYTE;
                  next_r.bitn = 4'd0;
                  next_r.shreg = byte_for(r, r.seq);
               end
               H_BYTE:
               begin
                  next_r.shreg = {r.shreg[6:0], 1'b1};
                  next_r.bitn = r.bitn + 4'd1;
                  if (r.bitn == 4'd8)
                  begin
                     next_r.bitn = 4'd0;
                     next_r.seq = r.seq + 2'd1;
                     if (r.nack || rd_byte || (!r.rd_op && r.seq == 2'd2))
                        next_r.st = H_STOP;
                     else if (r.rd_op && r.seq == 2'd1)
                        next_r.st = H_START;
                     else
                        next_r.shreg = byte_for(r, r.seq + 2'd1);
                     if (rd_byte)
                        next_r.rbyte = r.rx;
                  end
               end
               H_STOP:
               begin
                  next_r.st = H_IDLE;
                  next_r.busy = 1'b0;
               end
               H_IDLE:
               begin
                  next_r.st = H_IDLE;
               end
            endcase
         end
      end
      unique case (next_r.st)
         H_START:
         begin
            next_r.scl = next_r.q == 2'd1 || next_r.q == 2'd2;
            next_r.sda_rel = next_r.q < 2'd2;
         end
         H_BYTE:
         begin
            // Clock low in the first and last quarter, so data moves
            // a full quarter away from either clock edge.
            next_r.scl = next_r.q == 2'd1 || next_r.q == 2'd2;
            next_r.sda_rel = next_r.bitn == 4'd8 ||
               (next_r.rd_op && next_r.seq == 2'd3) || next_r.shreg[7];
         end
         H_STOP:
         begin
            next_r.scl = next_r.q != 2'd0;
            next_r.sda_rel = next_r.q[1];
         end
         H_IDLE:
         begin
            next_r.scl = 1'b1;
            next_r.sda_rel = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         r <= '0;
         r.st <= H_IDLE;
         r.scl <= 1'b1;
         r.sda_rel <= 1'b1;
         r.sda_sync <= 2'b11;
         r.target <= vai_pkg::SLAVE_ADDR_BASE;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign rdata = r.rd_q;
   assign lnk.scl = r.scl;
   assign lnk.sda_m_o = 1'b0;
   assign lnk.sda_m_oe_n = r.sda_rel;

endmodule

// file: tb/vai_link_monitor.sv
module vai_link_monitor (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic address_select_strap,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_m_o,
   input wire logic sda_m_oe_n,
   input wire logic sda_s_o,
   input wire logic sda_s_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;

   logic scl_q;
   logic sda_q;
   logic hit;
   logic rdm;
   logic [3:0] bit_n;
   logic [1:0] byte_n;
   logic [7:0] sh;
   logic [6:0] own;
   logic rise;
   logic ack;
   logic start_c;
   logic stop_c;

   // -------------------------------------------------------------
   // Frame tracking
   // -------------------------------------------------------------
   // The system clock oversamples the link, so edges are seen late.
   assign own = {6'h26, address_select_strap};
   assign rise = scl && !scl_q;
   assign ack = rise && bit_n == 4'h8;
   assign start_c = scl && scl_q && sda_q && !sda;
   assign stop_c = scl && scl_q && !sda_q && sda;

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         hit <= 1'b0;
         rdm <= 1'b0;
         bit_n <= 4'h0;
         byte_n <= 2'h0;
         sh <= 8'h00;
      end
      else
      begin
         scl_q <= scl;
         sda_q <= sda;
         if (start_c)
         begin
            bit_n <= 4'h0;
            byte_n <= 2'h0;
            hit <= 1'b0;
         end
         else if (rise)
         begin
            sh <= {sh[6:0], sda};
            bit_n <= (bit_n == 4'h8) ? 4'h0 : bit_n + 4'h1;
            if (ack && byte_n != 2'h3)
            begin
               byte_n <= byte_n + 2'h1;
            end
            if (ack && byte_n == 2'h0)
            begin
               hit <= sh[7:1] == own;
               rdm <= sh[0];
            end
            // A not-acknowledge ends the device's part in a read.
            if (ack && byte_n != 2'h0 && rdm && sda)
            begin
               hit <= 1'b0;
            end
         end
      end
   end

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   own_ack_a: assert property (
      ack && byte_n == 2'h0 && sh[7:1] == own |-> !sda_s_oe_n)
      else $error("own address not acknowledged");
   foreign_quiet_a: assert property (
      ack && byte_n == 2'h0 && sh[7:1] != own |-> sda_s_oe_n)
      else $error("foreign address acknowledged");
   write_ack_a: assert property (
      ack && byte_n != 2'h0 && hit && !rdm |-> !sda_s_oe_n)
      else $error("write byte not acknowledged");
   read_slot_a: assert property (
      ack && byte_n != 2'h0 && hit && rdm |-> sda_s_oe_n)
      else $error("device held the master acknowledge slot");
   master_quiet_a: assert property (
      rise && !ack && byte_n != 2'h0 && hit && rdm |-> sda_m_oe_n)
      else $error("master drove data during a read byte");
   dev_edge_a: assert property (
      $changed(sda_s_oe_n) |-> !scl)
      else $error("device moved data while clock high");
   low_only_a: assert property (
      !sda_s_oe_n |-> !sda_s_o && !sda)
      else $error("device drove data high");
   stop_free_a: assert property (
      stop_c |=> sda_s_oe_n [*8])
      else $error("device drove data after stop");

   cover property (ack && byte_n == 2'h2 && hit && !rdm);
   cover property (ack && byte_n == 2'h1 && hit && rdm && sda);
   cover property (ack && byte_n == 2'h0 && sh[7:1] != own);
endmodule

// file: tb/test_video_adc_i2c_control_port.sv
module test_video_adc_i2c_control_port;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic rd;
      logic [7:0] sub;
      logic [7:0] val;
   } vai_row_t;

   // Read rows give the expected value, write rows the data sent.
   localparam vai_row_t ROWS [28] = '{
      {1'b1, 8'h00, vai_pkg::CHIP_ID}, {1'b1, 8'h01, 8'h69},
      {1'b1, 8'h02, 8'hd0}, {1'b1, 8'h03, 8'h48}, {1'b1, 8'h08, 8'h80},
      {1'b1, 8'h10, 8'hb8}, {1'b1, 8'h1d, 8'h00}, {1'b0, 8'h01, 8'ha5},
      {1'b0, 8'h02, 8'h3c}, {1'b0, 8'h03, 8'h28}, {1'b0, 8'h10, 8'h05},
      {1'b0, 8'h08, 8'h11}, {1'b0, 8'h09, 8'h22}, {1'b0, 8'h0a, 8'h33},
      {1'b0, 8'h1d, 8'h01}, {1'b0, 8'h1e, 8'h14}, {1'b0, 8'h17, 8'h01},
      {1'b0, 8'h18, 8'h7e}, {1'b0, 8'h23, 8'h02}, {1'b0, 8'h0b, 8'hff},
      {1'b0, 8'h00, 8'hff}, {1'b1, 8'h01, 8'ha5}, {1'b1, 8'h02, 8'h30},
      {1'b1, 8'h03, 8'h28}, {1'b1, 8'h23, 8'h02}, {1'b1, 8'h0b, 8'h00},
      {1'b1, 8'h00, vai_pkg::CHIP_ID}, {1'b1, 8'h30, 8'h00}};

   logic clk_sys;
   logic rstn;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic address_select_strap;
   logic [11:0] pll_divider;
   logic [2:0] charge_pump_current;
   logic [2:0][7:0] programmable_gain_stage;
   logic [2:0] clamp_mid;
   logic [2:0][8:0] black_level;
   logic [2:0][8:0] channel_offset;
   logic offset_enable;
   logic [1:0] loop_mode;
   logic loop_run;
   logic [7:0] v;
   logic [7:0] s;
   int n_fail = 0;
   int samples_checked = 0;
   int cyc = 0;

   vai_link_if lnk();

   vai_host #(.QUARTER(4)) u_vai_host (.clk_sys(clk_sys), .rstn(rstn),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .lnk(lnk));

   vai_dev u_vai_dev (.rstn(rstn), .lnk(lnk),
      .address_select_strap(address_select_strap),
      .pll_divider(pll_divider), .charge_pump_current(charge_pump_current),
      .programmable_gain_stage(programmable_gain_stage),
      .clamp_mid(clamp_mid), .black_level(black_level),
      .channel_offset(channel_offset), .offset_enable(offset_enable),
      .loop_mode(loop_mode), .loop_run(loop_run));

   vai_link_monitor u_vai_link_monitor (.clk_sys(clk_sys), .rstn(rstn),
      .address_select_strap(address_select_strap), .scl(lnk.scl),
      .sda(lnk.sda), .sda_m_o(lnk.sda_m_o), .sda_m_oe_n(lnk.sda_m_oe_n),
      .sda_s_o(lnk.sda_s_o), .sda_s_oe_n(lnk.sda_s_oe_n));

   always #12.5 clk_sys = ~clk_sys;

   // -------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
      begin
         $display("DONE - PASS");
      end
      else
      begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // The idle cycle after each strobe keeps two tasks off one edge.
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [7:0] d, output logic [7:0] q);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk_sys);
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk_sys);
      q = rdata;
   endtask

   task automatic xfer(input logic r, input logic [7:0] sub,
                       input logic [7:0] d, output logic [7:0] q,
                       output logic [7:0] st);
      int n;
      n = 0;
      bus(1'b1, vai_pkg::H_SUB, sub, q);
      bus(1'b1, vai_pkg::H_WDATA, d, q);
      bus(1'b1, vai_pkg::H_CTRL, {6'h00, r, 1'b1}, q);
      st = 8'h01;
      while (st[vai_pkg::STAT_BUSY] !== 1'b0 && n < 1000)
      begin
         bus(1'b0, vai_pkg::H_STAT, 8'h00, st);
         n++;
      end
      chk(24'(n < 1000), 24'h000001);
      bus(1'b0, vai_pkg::H_RDATA, 8'h00, q);
   endtask

   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         n_fail++;
         complete_run();
      end
   end

   // -------------------------------------------------------------
   // Sequence
   // -------------------------------------------------------------
   initial
   begin
      clk_sys = 1'b0;
      rstn = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      address_select_strap = 1'b0;
      repeat (16) @(posedge clk_sys);
      rstn <= 1'b1;
      foreach (ROWS[i])
      begin
         xfer(ROWS[i].rd, ROWS[i].sub, ROWS[i].val, v, s);
         v = ROWS[i].rd ? v : {7'h00, s[vai_pkg::STAT_NACK]};
         chk(v, ROWS[i].val & {8{ROWS[i].rd}});
      end
      chk(pll_divider, 12'ha53);
      chk(charge_pump_current, 3'h5);
      chk(clamp_mid, 3'h5);
      chk(programmable_gain_stage, 24'h332211);
      chk({black_level[1], black_level[0]}, {9'h000, 9'h114});
      chk({channel_offset[0], offset_enable, loop_mode}, 12'hbf6);
      xfer(1'b0, vai_pkg::ADR_LOOP_CTRL, 8'h05, v, s);
      chk({offset_enable, loop_mode, loop_run}, 4'h3);
      bus(1'b1, vai_pkg::H_TARGET, 8'h4d, v);
      xfer(1'b0, vai_pkg::ADR_GAIN0, 8'h99, v, s);
      chk({s[vai_pkg::STAT_NACK], programmable_gain_stage[0]}, 9'h111);
      address_select_strap <= 1'b1;
      xfer(1'b0, 8'h09, 8'h44, v, s);
      chk({s[vai_pkg::STAT_NACK], programmable_gain_stage[1]}, 9'h044);
      bus(1'b0, 4'hf, 8'h00, v);
      chk(v, 8'h00);
      address_select_strap <= 1'b0;
      @(posedge clk_sys);
      rstn <= 1'b0;
      // Longer than the minimum pulse the host owes the device.
      repeat (48) @(posedge clk_sys);
      rstn <= 1'b1;
      bus(1'b0, vai_pkg::H_TARGET, 8'h00, v);
      chk(v, 8'h4c);
      xfer(1'b1, vai_pkg::ADR_DIV_UPPER, 8'h00, v, s);
      chk(v, 8'h69);
      chk(programmable_gain_stage, 24'h808080);
      chk({channel_offset[2], black_level[2]}, {9'h100, 9'h000});
      complete_run();
   end
endmodule
